// ---- logic/bit_skip_pkg.sv ----
// constants for the bit-test skip-if-clear execution block
package bit_skip_pkg;
	localparam int          OPCODE_W      = 14;
	localparam int          ADDR_W        = 7;
	localparam int          BITSEL_W      = 3;
	localparam int          DATA_W        = 8;
	localparam logic [3:0]  OP_TOP_PATTERN = 4'h6;
	localparam int          OP_TOP_MSB    = 13;
	localparam int          OP_TOP_LSB    = 10;
	localparam int          BITSEL_LSB    = 7;
	localparam int          ADDR_LSB      = 0;
	localparam real         CLK_PERIOD_NS = 20.0;
	typedef enum logic [1:0] {
		PHASE_Q1,
		PHASE_Q2,
		PHASE_Q3,
		PHASE_Q4
	} phase_t;
endpackage

// ---- logic/bit_select.sv ----
// picks one bit of a file register word and registers it
`timescale 1ns/1ps
module bit_select #(
	parameter int DATA_W = 8,
	parameter int SEL_W  = 3
) (
	// clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_n,
	// data and selector
	input  wire logic              i_load,
	input  wire logic [DATA_W-1:0] i_data,
	input  wire logic [SEL_W-1:0]  i_sel,
	// selected bit
	output logic                   o_bit
);
	logic bit_reg;
	logic bit_next;

	always_comb begin
		bit_next = bit_reg;
		if (i_load) begin
			bit_next = i_data[i_sel];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bit_reg <= 1'b0;
		end else begin
			bit_reg <= bit_next;
		end
	end

	assign o_bit = bit_reg;
endmodule

// ---- logic/bit_test_skip_clear_exec.sv ----
// execution of the bit test, skip if clear instruction
`timescale 1ns/1ps
module bit_test_skip_clear_exec #(
	parameter int OPCODE_W = bit_skip_pkg::OPCODE_W,
	parameter int ADDR_W   = bit_skip_pkg::ADDR_W,
	parameter int DATA_W   = bit_skip_pkg::DATA_W
) (
	// clock and reset
	input  wire logic                            i_ref_clk,
	input  wire logic                            i_rst_n,
	// fetched instruction, presented at Q1 of each instruction cycle
	input  wire logic                            i_q1_start,
	input  wire logic [OPCODE_W-1:0]             i_opcode,
	// file register read port
	output logic                                 o_rd_en,
	output logic [ADDR_W-1:0]                    o_rd_addr,
	input  wire logic [DATA_W-1:0]               i_rd_data,
	// status
	output logic                                 o_match,
	output logic                                 o_skip,
	output logic                                 o_flush_next,
	output logic                                 o_nop_cycle,
	output logic                                 o_reg_write,
	output logic [1:0]                           o_phase
);
	localparam int SEL_W = bit_skip_pkg::BITSEL_W;

	typedef enum {
		ST_IDLE,
		ST_READ,
		ST_PROC,
		ST_DONE,
		ST_SKIP,
		ST_PAD_Q2,
		ST_PAD_Q3,
		ST_PAD_Q4
	} state_t;

	// sequencer
	state_t                        state_reg;
	state_t                        state_next;
	bit_skip_pkg::phase_t          phase_reg;
	bit_skip_pkg::phase_t          phase_next;

	// operands captured at the take
	logic [ADDR_W-1:0]             addr_reg;
	logic [ADDR_W-1:0]             addr_next;
	logic [SEL_W-1:0]              sel_reg;
	logic [SEL_W-1:0]              sel_next;
	logic                          match_reg;
	logic                          match_next;

	// outcome flags
	logic                          skip_reg;
	logic                          skip_next;
	logic                          flush_reg;
	logic                          flush_next;
	logic                          nop_reg;
	logic                          nop_next;

	// strobes derived from the sequencer
	logic                          tested_bit;
	logic                          load_bit;
	logic                          take_instr;
	logic                          skip_taken;
	logic                          decide_now;
	logic                          op_is_match;

	function automatic logic is_bit_test_skip_if_clear(input logic [OPCODE_W-1:0] op);
		return op[bit_skip_pkg::OP_TOP_MSB:bit_skip_pkg::OP_TOP_LSB]
			== bit_skip_pkg::OP_TOP_PATTERN;
	endfunction

	// tested bit is registered at the end of Q2 so the Q4 decision sees a settled value
	bit_select #(
		.DATA_W (DATA_W),
		.SEL_W  (SEL_W)
	) u_bit_select (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_load    (load_bit),
		.i_data    (i_rd_data),
		.i_sel     (sel_reg),
		.o_bit     (tested_bit)
	);

	// read strobe only in Q2 of the first cycle
	assign load_bit    = (state_reg == ST_READ);
	assign o_rd_en     = load_bit;
	assign o_rd_addr   = addr_reg;

	// a new opcode is only taken while idle; mid-instruction strobes are ignored
	assign take_instr  = (state_reg == ST_IDLE) && i_q1_start;
	// the strobe opening the inserted cycle is consumed, its opcode never decoded
	assign skip_taken  = (state_reg == ST_SKIP) && i_q1_start;
	assign decide_now  = (state_reg == ST_DONE);
	assign op_is_match = is_bit_test_skip_if_clear(i_opcode);

	// sequencer: one clock per quarter phase after the Q1 strobe
	always_comb begin
		state_next = state_reg;
		phase_next = phase_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (i_q1_start) begin
					phase_next = bit_skip_pkg::PHASE_Q1;
					if (op_is_match) begin
						state_next = ST_READ;
					end
				end
			end
			ST_READ: begin
				phase_next = bit_skip_pkg::PHASE_Q2;
				state_next = ST_PROC;
			end
			ST_PROC: begin
				phase_next = bit_skip_pkg::PHASE_Q3;
				state_next = ST_DONE;
			end
			ST_DONE: begin
				// Q4 is idle; decision lands here
				phase_next = bit_skip_pkg::PHASE_Q4;
				if (!tested_bit) begin
					state_next = ST_SKIP;
				end else begin
					state_next = ST_IDLE;
				end
			end
			ST_SKIP: begin
				// whole second cycle is a no_operation; waits for its Q1
				if (i_q1_start) begin
					phase_next = bit_skip_pkg::PHASE_Q1;
					state_next = ST_PAD_Q2;
				end
			end
			// inserted cycle walks its quarter phases and touches nothing
			ST_PAD_Q2: begin
				phase_next = bit_skip_pkg::PHASE_Q2;
				state_next = ST_PAD_Q3;
			end
			ST_PAD_Q3: begin
				phase_next = bit_skip_pkg::PHASE_Q3;
				state_next = ST_PAD_Q4;
			end
			ST_PAD_Q4: begin
				phase_next = bit_skip_pkg::PHASE_Q4;
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
			phase_reg <= bit_skip_pkg::PHASE_Q1;
		end else begin
			state_reg <= state_next;
			phase_reg <= phase_next;
		end
	end

	// operands held from one take to the next, so the read address stays still
	always_comb begin
		addr_next  = addr_reg;
		sel_next   = sel_reg;
		match_next = match_reg;
		if (take_instr) begin
			match_next = op_is_match;
			addr_next  = i_opcode[bit_skip_pkg::ADDR_LSB +: ADDR_W];
			sel_next   = i_opcode[bit_skip_pkg::BITSEL_LSB +: SEL_W];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_reg  <= '0;
			sel_reg   <= '0;
			match_reg <= 1'b0;
		end else begin
			addr_reg  <= addr_next;
			sel_reg   <= sel_next;
			match_reg <= match_next;
		end
	end

	// a take and a decision never share a cycle, so the order below is not a priority
	always_comb begin
		skip_next  = skip_reg;
		flush_next = 1'b0;
		nop_next   = nop_reg;
		if (take_instr) begin
			skip_next = 1'b0;
			nop_next  = 1'b0;
		end else if (decide_now && !tested_bit) begin
			skip_next  = 1'b1;
			flush_next = 1'b1;
		end else if (skip_taken) begin
			skip_next = 1'b0;
			nop_next  = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			skip_reg  <= 1'b0;
			flush_reg <= 1'b0;
			nop_reg   <= 1'b0;
		end else begin
			skip_reg  <= skip_next;
			flush_reg <= flush_next;
			nop_reg   <= nop_next;
		end
	end

	assign o_match      = match_reg;
	assign o_skip       = skip_reg;
	assign o_flush_next = flush_reg;
	assign o_nop_cycle  = nop_reg;
	// this instruction never writes a file register, neither cycle
	assign o_reg_write  = 1'b0;
	assign o_phase      = phase_reg;
endmodule

// ---- verif/btsc_asserts.sv ----
// assertions for the bit-test skip-if-clear block
`timescale 1ns/1ps
module btsc_asserts (
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	input wire logic [13:0] i_opcode,
	input wire logic        o_rd_en,
	input wire logic [6:0]  o_rd_addr,
	input wire logic [7:0]  i_rd_data,
	input wire logic        o_match,
	input wire logic        o_skip,
	input wire logic        o_flush_next,
	input wire logic        o_nop_cycle,
	input wire logic        o_reg_write,
	input wire logic [1:0]  o_phase
);
	logic [13:0] op_q;
	always_ff @(posedge i_ref_clk) op_q <= i_opcode;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_q; o_phase == 2'h1 ##1 o_phase == 2'h2 ##1 o_phase == 2'h3; endsequence
	property p_dec; $rose(o_rd_en) |-> o_match == (op_q[13:10] == 4'h6); endproperty
	property p_adr; $rose(o_rd_en) |-> o_rd_addr == op_q[6:0]; endproperty
	property p_clr; o_rd_en && o_match && !i_rd_data[op_q[9:7]] |-> ##[1:4] o_flush_next; endproperty
	property p_set; o_rd_en && o_match && i_rd_data[op_q[9:7]] |=> !o_flush_next [*4]; endproperty
	property p_fl; o_flush_next |-> o_skip ##1 !o_flush_next; endproperty
	property p_nop; $rose(o_nop_cycle) |-> !o_skip && $past(o_skip); endproperty
	property p_ph; o_rd_en |=> s_q; endproperty
	property p_wr; !o_reg_write; endproperty
	a_dec: assert property (p_dec) else $error("decode");
	a_adr: assert property (p_adr) else $error("address");
	a_clr: assert property (p_clr) else $error("no skip");
	a_set: assert property (p_set) else $error("bad skip");
	a_fl: assert property (p_fl) else $error("flush");
	a_nop: assert property (p_nop) else $error("nop");
	a_ph: assert property (p_ph) else $error("phase");
	a_wr: assert property (p_wr) else $error("write");
endmodule
bind bit_test_skip_clear_exec btsc_asserts chk_u (
	.i_ref_clk    (i_ref_clk),
	.i_rst_n      (i_rst_n),
	.i_opcode     (i_opcode),
	.o_rd_en      (o_rd_en),
	.o_rd_addr    (o_rd_addr),
	.i_rd_data    (i_rd_data),
	.o_match      (o_match),
	.o_skip       (o_skip),
	.o_flush_next (o_flush_next),
	.o_nop_cycle  (o_nop_cycle),
	.o_reg_write  (o_reg_write),
	.o_phase      (o_phase)
);

// ---- verif/bit_test_skip_clear_exec_tb_top.sv ----
// self-checking bench for the bit-test skip-if-clear block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t %h %h", $time, (a), (e)); end end
module bit_test_skip_clear_exec_tb_top;
	logic        i_ref_clk = 0;
	logic        i_rst_n = 0;
	logic        i_q1_start = 0;
	logic [13:0] i_opcode = 14'h0000;
	logic [7:0]  i_rd_data = 8'h00;
	logic        o_rd_en, o_match, o_skip, o_flush_next, o_nop_cycle, o_reg_write, seen;
	logic [6:0]  o_rd_addr;
	logic [1:0]  o_phase;
	int          mismatches = 0, checks = 0, cyc = 0;
	// skip expected, opcode, file data
	logic [31:0] rows [6] = '{32'h001b_ff80, 32'h011b_ff7f, 32'h0118_00fe, 32'h0018_0001,
		32'h001c_8000, 32'h0014_8000};
	bit_test_skip_clear_exec dut_u (
		.i_ref_clk    (i_ref_clk),
		.i_rst_n      (i_rst_n),
		.i_q1_start   (i_q1_start),
		.i_opcode     (i_opcode),
		.o_rd_en      (o_rd_en),
		.o_rd_addr    (o_rd_addr),
		.i_rd_data    (i_rd_data),
		.o_match      (o_match),
		.o_skip       (o_skip),
		.o_flush_next (o_flush_next),
		.o_nop_cycle  (o_nop_cycle),
		.o_reg_write  (o_reg_write),
		.o_phase      (o_phase)
	);
	always #10 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) if (++cyc == 1000) begin
		mismatches++;
		finish_test();
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic q1;
		@(posedge i_ref_clk) #1 i_q1_start = 1;
		@(posedge i_ref_clk) #1 i_q1_start = 0;
	endtask
	task automatic run(input logic [31:0] r);
		repeat (2) @(posedge i_ref_clk);
		#1 i_opcode = r[21:8];
		i_rd_data = r[7:0];
		seen = 0;
		q1();
		`CHK(o_match, r[21:18] == 4'h6)
		`CHK(o_rd_en, r[21:18] == 4'h6)
		if (r[21:18] == 4'h6) `CHK(o_rd_addr, r[14:8])
		repeat (6) begin
			@(posedge i_ref_clk);
			#1 seen |= o_flush_next;
		end
		`CHK(seen, r[24])
		`CHK(o_skip, r[24])
		`CHK(o_phase, (r[21:18] == 4'h6) ? 2'h3 : 2'h0)
		// opcode still matches: the nop cycle must not decode it again
		if (r[24]) begin
			q1();
			`CHK({o_nop_cycle, o_skip}, 2'h2)
			repeat (3) @(posedge i_ref_clk);
			#1 `CHK({o_rd_en, o_phase}, 3'h3)
		end
	endtask
	initial begin
		repeat (5) @(posedge i_ref_clk);
		#1 i_rst_n = 1;
		`CHK({o_skip, o_match, o_nop_cycle, o_flush_next, o_rd_en, o_reg_write, o_phase}, 8'h00)
		foreach (rows[k]) run(rows[k]);
		i_opcode = 14'h1800;
		i_rd_data = 8'h00;
		q1();
		repeat (5) @(posedge i_ref_clk);
		#1 `CHK(o_skip, 1'b1)
		i_rst_n = 0;
		#1 `CHK({o_skip, o_match, o_nop_cycle, o_phase}, 5'h00)
		@(posedge i_ref_clk);
		#1 i_rst_n = 1;
		run(rows[1]);
		finish_test();
	end
endmodule
